// ---- design/bpf_osc.sv ----
// internal oscillator: eight slots per 4 ms period
`timescale 1ns/1ns
module bpf_osc #(
  parameter int unsigned SLOT_CYCLES = bpf_pkg::SLOT_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  bpf_tick_if.src   tick
);
  logic [31:0] div_q;
  logic [2:0]  slot_q;
  logic        stick_q;
  logic        ptick_q;

  // slot divider; each slot is one eighth of the period
  always_ff @(posedge sys_clk) begin
    if (rst || div_q == SLOT_CYCLES - 1) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // eight-slot sequence counter, wraps every period
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slot_q  <= 3'h0;
      stick_q <= 1'b0;
      ptick_q <= 1'b0;
    end else begin
      stick_q <= (div_q == SLOT_CYCLES - 1);
      ptick_q <= (div_q == SLOT_CYCLES - 1) && (slot_q == bpf_pkg::SLOT_LAST);
      if (div_q == SLOT_CYCLES - 1) begin
        slot_q <= slot_q + 3'h1;
      end
    end
  end

  assign tick.slot_tick   = stick_q;
  assign tick.period_tick = ptick_q;
  assign tick.slot_idx    = slot_q;
endmodule

// ---- design/bpf_pkg.sv ----
// package of constants and types for the two-cell protection controller
// Overview of operation
// - charger present, both cells normal, tap connected: switch closed.
// - no charger, normal cells, tap connected, normal load: switch closed.
// - overcharge with charger present ends with switch open and bleeding enabled.
// - grace granted only after overcharge persists beyond two oscillator periods.
// - after qualified overcharge keep charging for capacitor-set grace, then open; here the grace is set by the GRACE_PERIODS parameter, in oscillator periods.
// - after grace, bleed the overcharged cells only while a charger stays present.
// - overcharged cells back to normal: close switch, restart detection cycle.
// - overcharged cells with load, no charger: close switch to feed load.
// - a cell over-discharged, no charger: open switch, enter shutdown.
// - over-discharged with charger: switch on seven eighths of each period.
// - during the off eighth, test charger; stop charging when it is gone.
// - both cells normal again during over-discharge charging: continuous charging.
// - battery under lockout: switch open until charger seen, then undervoltage mode.
// - charger counts as present only above the charger detect threshold.
// - undervoltage mode: switch on one eighth, off time confirms charger.
// - battery above lockout while charging: move to over-discharge charging.
// - sense voltage above short trip threshold opens the switch.
// - after short trip switch stays open until load fully removed.
// - after short trip enable pull current; node high means short, low removed.
// - pull current flows while short persists until over-discharge; removal recloses.
// - center tap lost: open switch until connection restored.
// - tap open, undervoltage, charger: charge at one eighth until over-discharge level.
// - overcharge without charger under normal load: cycle at very high duty.
package bpf_pkg;
  localparam int unsigned SYS_CLK_MHZ      = 125;
  localparam int unsigned OSC_PERIOD_US    = 4000;
  localparam int unsigned OSC_PERIOD_CYC   = OSC_PERIOD_US * SYS_CLK_MHZ;
  localparam int unsigned SLOT_US          = OSC_PERIOD_US / 8;
  localparam int unsigned SLOT_CYC         = SLOT_US * SYS_CLK_MHZ;
  localparam int unsigned OC_QUAL_PERIODS  = 2;
  localparam int unsigned GRACE_PERIODS    = 16;
  localparam logic [2:0]  SLOT_LAST        = 3'h7;
  localparam logic [2:0]  SLOT_OFF_SEVEN   = 3'h7;
  localparam logic [2:0]  SLOT_ON_ONE      = 3'h0;
  localparam logic [15:0] CNT_ZERO         = 16'h0000;

  typedef enum logic [1:0] {BPF_CELL_ODC, BPF_CELL_NORM, BPF_CELL_OC} bpf_cell_t;

  typedef enum {
    BPF_NORMAL, BPF_OC_QUAL, BPF_OC_GRACE, BPF_OC_BLEED, BPF_ODC_CHG,
    BPF_SHUTDOWN, BPF_UV_CHG, BPF_SHORT
  } bpf_state_t;
endpackage

// ---- design/bpf_tick_if.sv ----
// interface carrying oscillator slot ticks between controller modules
`timescale 1ns/1ns
interface bpf_tick_if;
  logic       slot_tick;
  logic       period_tick;
  logic [2:0] slot_idx;
  modport src (output slot_tick, output period_tick, output slot_idx);
  modport dst (input slot_tick, input period_tick, input slot_idx);
endinterface

// ---- design/bpf_top.sv ----
// protection state machine driving the low-side switch gate
`timescale 1ns/1ns
module bpf_top #(
  parameter int unsigned SLOT_CYCLES   = bpf_pkg::SLOT_CYC,
  parameter int unsigned GRACE_PERIODS = bpf_pkg::GRACE_PERIODS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] high_cell_level,
  input  wire logic [1:0] low_cell_level,
  input  wire logic       battery_below_lockout,
  input  wire logic       charger_detect_raw,
  input  wire logic       load_current_sense,
  input  wire logic       load_present_sense,
  input  wire logic       tap_open_raw,
  output logic            switch_gate_drive,
  output logic            cell_bleed_high,
  output logic            cell_bleed_low,
  output logic            short_release_pull_current,
  output logic            shutdown_mode
);
  bpf_tick_if tick ();

  bpf_osc #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_osc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick)
  );

  // three-stage synchronisers for analog comparator outputs
  logic [6:0] s1_q, s2_q, s3_q, flt_q;
  logic [6:0] raw_in;
  assign raw_in = {charger_detect_raw, load_current_sense, load_present_sense,
                   tap_open_raw, battery_below_lockout,
                   (high_cell_level == 2'(bpf_pkg::BPF_CELL_OC)),
                   (low_cell_level == 2'(bpf_pkg::BPF_CELL_OC))};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      // change accepted once stages two and three agree
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          flt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // odc levels synchronised separately
  logic [1:0] od1_q, od2_q, od3_q, odf_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      od1_q <= 2'h0;
      od2_q <= 2'h0;
      od3_q <= 2'h0;
      odf_q <= 2'h0;
    end else begin
      od1_q <= {high_cell_level == 2'(bpf_pkg::BPF_CELL_ODC),
                low_cell_level == 2'(bpf_pkg::BPF_CELL_ODC)};
      od2_q <= od1_q;
      od3_q <= od2_q;
      if (od2_q[1] == od3_q[1]) begin
        odf_q[1] <= od3_q[1];
      end
      if (od2_q[0] == od3_q[0]) begin
        odf_q[0] <= od3_q[0];
      end
    end
  end

  logic chg, short_trip, load_on, tap_open, uv, oc_hi, oc_lo, oc_any, odc_any;
  assign chg        = flt_q[6];
  assign short_trip = flt_q[5];
  assign load_on    = flt_q[4];
  assign tap_open   = flt_q[3];
  assign uv         = flt_q[2];
  assign oc_hi      = flt_q[1];
  assign oc_lo      = flt_q[0];
  assign oc_any     = oc_hi | oc_lo;
  assign odc_any    = |odf_q;

  // duty pattern decode from the eight-slot sequence
  function automatic logic duty_on(input logic [2:0] slot, input logic seven);
    if (seven) begin
      duty_on = (slot != bpf_pkg::SLOT_OFF_SEVEN);
    end else begin
      duty_on = (slot == bpf_pkg::SLOT_ON_ONE);
    end
  endfunction

  logic       off_slot;
  assign off_slot = (tick.slot_idx == bpf_pkg::SLOT_OFF_SEVEN);

  bpf_pkg::bpf_state_t state_q, state_d;
  logic [15:0] tmr_q;
  logic        tmr_done;
  assign tmr_done = (tmr_q == bpf_pkg::CNT_ZERO);

  // next state; short also forced here with top priority, open tap used here only to pick the exit from undervoltage charging
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bpf_pkg::BPF_NORMAL: begin
        if (short_trip) begin
          state_d = bpf_pkg::BPF_SHORT;
        end else if (uv) begin
          state_d = chg ? bpf_pkg::BPF_UV_CHG : bpf_pkg::BPF_SHUTDOWN;
        end else if (odc_any) begin
          state_d = chg ? bpf_pkg::BPF_ODC_CHG : bpf_pkg::BPF_SHUTDOWN;
        end else if (oc_any && chg) begin
          state_d = bpf_pkg::BPF_OC_QUAL;
        end
      end
      bpf_pkg::BPF_OC_QUAL: begin
        if (!oc_any || !chg) begin
          state_d = bpf_pkg::BPF_NORMAL;
        end else if (tmr_done) begin
          state_d = bpf_pkg::BPF_OC_GRACE;
        end
      end
      bpf_pkg::BPF_OC_GRACE: begin
        if (!oc_any) begin
          state_d = bpf_pkg::BPF_NORMAL;
        end else if (tmr_done) begin
          state_d = bpf_pkg::BPF_OC_BLEED;
        end
      end
      bpf_pkg::BPF_OC_BLEED: begin
        if (!oc_any || !chg) begin
          state_d = bpf_pkg::BPF_NORMAL;
        end
      end
      bpf_pkg::BPF_ODC_CHG: begin
        if (uv) begin
          state_d = bpf_pkg::BPF_UV_CHG;
        end else if (!odc_any) begin
          state_d = bpf_pkg::BPF_NORMAL;
        end else if (off_slot && tick.slot_tick && !chg) begin
          state_d = bpf_pkg::BPF_SHUTDOWN;
        end
      end
      bpf_pkg::BPF_UV_CHG: begin
        if (!uv && !tap_open) begin
          state_d = bpf_pkg::BPF_ODC_CHG;
        end else if (!uv && tap_open) begin
          state_d = bpf_pkg::BPF_SHUTDOWN;
        end else if (off_slot && tick.slot_tick && !chg) begin
          state_d = bpf_pkg::BPF_SHUTDOWN;
        end
      end
      bpf_pkg::BPF_SHUTDOWN: begin
        if (chg) begin
          if (uv) begin
            state_d = bpf_pkg::BPF_UV_CHG;
          end else if (odc_any) begin
            state_d = bpf_pkg::BPF_ODC_CHG;
          end else begin
            state_d = bpf_pkg::BPF_NORMAL;
          end
        end else if (!uv && !odc_any) begin
          state_d = bpf_pkg::BPF_NORMAL;
        end
      end
      bpf_pkg::BPF_SHORT: begin
        // the sense node only means removal once the open switch has cleared the trip
        if (!load_on && !short_trip) begin
          state_d = bpf_pkg::BPF_NORMAL;
        end else if (odc_any || uv) begin
          state_d = bpf_pkg::BPF_SHUTDOWN;
        end
      end
    endcase
    if (short_trip && state_q != bpf_pkg::BPF_SHORT) begin
      state_d = bpf_pkg::BPF_SHORT;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= bpf_pkg::BPF_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // qualify and grace timer in oscillator periods; loaded on entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmr_q <= bpf_pkg::CNT_ZERO;
    end else if (state_d != state_q) begin
      if (state_d == bpf_pkg::BPF_OC_QUAL) begin
        // one extra tick: the first may land just after entry, so wait past two periods
        tmr_q <= 16'(bpf_pkg::OC_QUAL_PERIODS + 1);
      end else begin
        tmr_q <= 16'(GRACE_PERIODS - 1);
      end
    end else if (tick.period_tick && !tmr_done) begin
      tmr_q <= tmr_q - 16'h0001;
    end
  end

  // gate decision; short overrides everything, tap open everything except undervoltage charging
  logic gate_d;
  always_comb begin
    gate_d = 1'b0;
    unique case (state_q)
      bpf_pkg::BPF_NORMAL: begin
        // overcharge on load without charger cycles at seven eighths
        gate_d = (oc_any && !chg && load_on) ? duty_on(tick.slot_idx, 1'b1)
                                             : !(oc_any && !load_on);
      end
      bpf_pkg::BPF_OC_QUAL:  gate_d = 1'b1;
      bpf_pkg::BPF_OC_GRACE: gate_d = 1'b1;
      bpf_pkg::BPF_OC_BLEED: gate_d = 1'b0;
      bpf_pkg::BPF_ODC_CHG:  gate_d = duty_on(tick.slot_idx, 1'b1);
      bpf_pkg::BPF_UV_CHG:   gate_d = duty_on(tick.slot_idx, 1'b0);
      bpf_pkg::BPF_SHUTDOWN: gate_d = 1'b0;
      bpf_pkg::BPF_SHORT:    gate_d = 1'b0;
    endcase
    if (short_trip) begin
      gate_d = 1'b0;
    end
    if (tap_open && state_q != bpf_pkg::BPF_UV_CHG) begin
      gate_d = 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      switch_gate_drive          <= 1'b0;
      cell_bleed_high            <= 1'b0;
      cell_bleed_low             <= 1'b0;
      short_release_pull_current <= 1'b0;
      shutdown_mode              <= 1'b0;
    end else begin
      switch_gate_drive          <= gate_d;
      cell_bleed_high            <= (state_q == bpf_pkg::BPF_OC_BLEED) && chg && oc_hi;
      cell_bleed_low             <= (state_q == bpf_pkg::BPF_OC_BLEED) && chg && oc_lo;
      short_release_pull_current <= (state_q == bpf_pkg::BPF_SHORT);
      shutdown_mode              <= (state_q == bpf_pkg::BPF_SHUTDOWN);
    end
  end
endmodule

// ---- testbench/bpf_pack_model.sv ----
// pack side model: a load or a short and the node they lift
`timescale 1ns/1ns
module bpf_pack_model (
  input  wire logic switch_gate_drive,
  input  wire logic short_on,
  input  wire logic load_on,
  output logic      load_current_sense,
  output logic      load_present_sense
);
  // short current only flows through a closed switch
  assign load_current_sense = short_on & switch_gate_drive;
  // a normal load reads as present; an open switch with a short leaves the node near top
  assign load_present_sense = load_on | (short_on & !switch_gate_drive);
endmodule

// ---- testbench/bpf_top_properties.sv ----
// concurrent checks on the protection controller ports
`timescale 1ns/1ns
module bpf_top_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [1:0] high_cell_level,
  input wire logic [1:0] low_cell_level,
  input wire logic       battery_below_lockout,
  input wire logic       charger_detect_raw,
  input wire logic       load_current_sense,
  input wire logic       load_present_sense,
  input wire logic       tap_open_raw,
  input wire logic       switch_gate_drive,
  input wire logic       cell_bleed_high,
  input wire logic       cell_bleed_low,
  input wire logic       short_release_pull_current,
  input wire logic       shutdown_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // eight stable cycles clear the input filters
  sequence s_healthy;
    (high_cell_level == 2'h1 && low_cell_level == 2'h1 && !tap_open_raw
      && !battery_below_lockout && !load_current_sense && !load_present_sense) [*8];
  endsequence
  property p_healthy; s_healthy |-> ##[0:4] switch_gate_drive; endproperty
  a_healthy: assert property (p_healthy) else $error("switch open on healthy pack");
  property p_short; $rose(load_current_sense) |-> ##[1:8] !switch_gate_drive; endproperty
  a_short: assert property (p_short) else $error("short left switch closed");
  property p_tap; (tap_open_raw && !battery_below_lockout) [*8] |-> !switch_gate_drive; endproperty
  a_tap: assert property (p_tap) else $error("switch closed with tap open");
  // charger loss is only seen at a slot end, so allow a full period
  sequence s_odc_idle;
    ((high_cell_level == 2'h0 || low_cell_level == 2'h0) && !charger_detect_raw
      && !battery_below_lockout) [*8];
  endsequence
  property p_odc; s_odc_idle |-> ##[0:40] shutdown_mode; endproperty
  a_odc: assert property (p_odc) else $error("no shutdown on discharged cell");
  property p_shut; shutdown_mode |-> !switch_gate_drive; endproperty
  a_shut: assert property (p_shut) else $error("switch closed in shutdown");
  property p_bchg; (!charger_detect_raw) [*8] |-> !cell_bleed_high && !cell_bleed_low; endproperty
  a_bchg: assert property (p_bchg) else $error("bleeding without charger");
  property p_bopen; cell_bleed_high || cell_bleed_low |-> !switch_gate_drive; endproperty
  a_bopen: assert property (p_bopen) else $error("bleeding with switch closed");
  property p_pull; short_release_pull_current |-> !switch_gate_drive; endproperty
  a_pull: assert property (p_pull) else $error("pull current with switch closed");
endmodule
bind bpf_top bpf_top_properties i_prop (.sys_clk(sys_clk), .rst(rst),
  .high_cell_level(high_cell_level), .low_cell_level(low_cell_level),
  .battery_below_lockout(battery_below_lockout), .charger_detect_raw(charger_detect_raw),
  .load_current_sense(load_current_sense), .load_present_sense(load_present_sense),
  .tap_open_raw(tap_open_raw), .switch_gate_drive(switch_gate_drive),
  .cell_bleed_high(cell_bleed_high), .cell_bleed_low(cell_bleed_low),
  .short_release_pull_current(short_release_pull_current), .shutdown_mode(shutdown_mode));

// ---- testbench/bpf_top_tb.sv ----
// self-checking bench for the protection controller
`timescale 1ns/1ns
module bpf_top_tb;
  logic            sys_clk  = 1'b0;
  logic            rst      = 1'b1;
  logic [1:0]      hcl      = 2'h1;
  logic [1:0]      lcl      = 2'h1;
  logic            chg      = 1'b0;
  logic            lock     = 1'b0;
  logic            tap      = 1'b0;
  logic            short_on = 1'b0;
  logic            load_on  = 1'b0;
  logic            gate, bl_h, bl_l, pull, shut, lcs, lps;
  logic [7:0]      n;
  int              err_count   = 0;
  int              comparisons = 0;
  int              cyc         = 0;
  wire logic [7:0] obs = {3'h0, gate, bl_h, bl_l, pull, shut};
  wire logic [7:0] g8  = {7'h00, gate};
  // short slots and grace keep the run brief
  bpf_top #(.SLOT_CYCLES(4), .GRACE_PERIODS(2)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .high_cell_level(hcl), .low_cell_level(lcl), .battery_below_lockout(lock),
    .charger_detect_raw(chg), .load_current_sense(lcs), .load_present_sense(lps),
    .tap_open_raw(tap), .switch_gate_drive(gate), .cell_bleed_high(bl_h),
    .cell_bleed_low(bl_l), .short_release_pull_current(pull), .shutdown_mode(shut));
  bpf_pack_model i_pack (.switch_gate_drive(gate), .short_on(short_on), .load_on(load_on),
    .load_current_sense(lcs), .load_present_sense(lps));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // hang guard, a few times the expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count = err_count + 1;
      test_done();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // drive cells, charger, lockout and tap, then let the filters settle
  task automatic st(input logic [1:0] h, input logic [1:0] l, input logic c,
                    input logic k, input logic t, input int w);
    @(posedge sys_clk);
    hcl <= h;
    lcl <= l;
    chg <= c;
    lock <= k;
    tap <= t;
    wt(w);
  endtask
  // switch-on cycles over two whole periods
  task automatic cnt(output logic [7:0] k);
    k = 8'h00;
    // sample after the edge so the gate has settled
    repeat (64) begin
      @(posedge sys_clk);
      #1;
      k = k + g8;
    end
  endtask
  task automatic t_normal();
    st(2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 12);
    check(obs, 8'h10);
    st(2'h1, 2'h1, 1'b1, 1'b0, 1'b0, 12);
    check(obs, 8'h10);
    $display("t_normal done");
  endtask
  // high cell first, then low cell; charger dropped only on the first pass
  task automatic t_over();
    for (int i = 0; i < 2; i++) begin
      st(i ? 2'h1 : 2'h2, i ? 2'h2 : 2'h1, 1'b1, 1'b0, 1'b0, 100);
      check(obs, 8'h10);
      wt(200);
      check(obs, i ? 8'h04 : 8'h08);
      st(i ? 2'h1 : 2'h2, i ? 2'h2 : 2'h1, i[0], 1'b0, 1'b0, 20);
      check(obs, i ? 8'h04 : 8'h00);
      if (i == 0) begin
        @(posedge sys_clk);
        load_on <= 1'b1;
        wt(12);
        cnt(n);
        check(n, 8'h38);
        @(posedge sys_clk);
        load_on <= 1'b0;
      end
      st(2'h1, 2'h1, i[0], 1'b0, 1'b0, 20);
      check(obs, 8'h10);
    end
    $display("t_over done");
  endtask
  task automatic t_odc();
    st(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 20);
    check(obs, 8'h01);
    st(2'h1, 2'h0, 1'b1, 1'b0, 1'b0, 40);
    cnt(n);
    check(n, 8'h38);
    st(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 48);
    check(obs, 8'h01);
    st(2'h1, 2'h0, 1'b1, 1'b0, 1'b0, 40);
    st(2'h1, 2'h1, 1'b1, 1'b0, 1'b0, 20);
    cnt(n);
    check(n, 8'h40);
    $display("t_odc done");
  endtask
  task automatic t_uv();
    st(2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 20);
    check(g8, 8'h00);
    st(2'h0, 2'h0, 1'b1, 1'b1, 1'b0, 40);
    cnt(n);
    check(n, 8'h08);
    st(2'h0, 2'h0, 1'b1, 1'b1, 1'b1, 40);
    cnt(n);
    check(n, 8'h08);
    st(2'h0, 2'h0, 1'b1, 1'b1, 1'b0, 40);
    st(2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 40);
    cnt(n);
    check(n, 8'h38);
    $display("t_uv done");
  endtask
  task automatic t_short();
    st(2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 12);
    @(posedge sys_clk);
    short_on <= 1'b1;
    wt(12);
    check(obs, 8'h02);
    wt(40);
    check(obs, 8'h02);
    @(posedge sys_clk);
    short_on <= 1'b0;
    wt(16);
    check(obs, 8'h10);
    // a short that outlasts the cells ends in shutdown
    @(posedge sys_clk);
    short_on <= 1'b1;
    wt(12);
    st(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 12);
    check(obs, 8'h01);
    @(posedge sys_clk);
    short_on <= 1'b0;
    st(2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 16);
    check(obs, 8'h10);
    $display("t_short done");
  endtask
  task automatic t_tap();
    st(2'h1, 2'h1, 1'b1, 1'b0, 1'b1, 12);
    check(g8, 8'h00);
    st(2'h1, 2'h1, 1'b1, 1'b0, 1'b0, 12);
    check(g8, 8'h01);
    $display("t_tap done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_normal();
    t_over();
    t_odc();
    t_uv();
    t_short();
    t_tap();
    test_done();
  end
endmodule
